/* File: rtl/astx_uart.sv */
// full-duplex asynchronous serial transmitter/receiver with baud generator
`timescale 1ns/10ps

module astx_uart
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // serial pins
   input  wire logic        serial_rx_pin,
   output logic             serial_tx_pin,
   // events
   output logic             tx_complete_irq,
   output logic             rx_complete_irq
);

   // ==========================================
   // helpers
   function automatic logic [11:0] astx_frame(input logic [7:0] d,
                                             input astx_pkg::astx_mode_t m);
      logic [11:0] f;
      logic        ones;
      logic        pb;
      ones = m.len8 ? ^d : ^d[6:0];
      f    = 12'hFFF;
      f[0] = 1'b0;
      case (m.par)
         astx_pkg::PAR_ZERO: pb = 1'b0;
         astx_pkg::PAR_ODD:  pb = ~ones;
         astx_pkg::PAR_EVEN: pb = ones;
         default:            pb = 1'b1;
      endcase
      if (m.len8)
      begin
         f[8:1] = d;
         f[9]   = pb;
      end
      else
      begin
         f[7:1] = d[6:0];
         f[8]   = pb;
      end
      return f;
   endfunction

   // number of data bits plus parity slot
   function automatic logic [3:0] astx_body(input astx_pkg::astx_mode_t m);
      logic [3:0] n;
      n = m.len8 ? 4'h8 : 4'h7;
      if (m.par != astx_pkg::PAR_NONE)
         n = n + 4'h1;
      return n;
   endfunction

   astx_pkg::astx_state_t s_reg;
   astx_pkg::astx_state_t s_next;

   // ==========================================
   // next state
   always_comb
   begin
      logic       setup;
      logic       acc;
      logic       tick;
      logic [3:0] mask;
      logic       rx_in;
      logic       fall;
      logic       bit_end;
      logic       rx_end;
      logic [7:0] data;
      logic       perr;
      logic [4:0] km1;
      s_next  = s_reg;
      setup   = psel & ~penable;
      acc     = psel & penable & s_reg.pready;
      tick    = 1'b0;
      mask    = 4'h0;
      rx_in   = 1'b1;
      fall    = 1'b0;
      bit_end = 1'b0;
      rx_end  = 1'b0;
      data    = 8'h00;
      perr    = 1'b0;
      km1     = s_reg.brg.k - 5'h01;

      s_next.tx_irq = 1'b0;
      s_next.rx_irq = 1'b0;

      // --- bus: answer in the access phase with no wait state
      s_next.pready  = setup;
      s_next.pslverr = 1'b0;
      if (setup)
      begin
         s_next.prdata = 32'h0000_0000;
         case (paddr)
            astx_pkg::ADDR_MODE: s_next.prdata[7:0] = s_reg.mode;
            astx_pkg::ADDR_ERR:  s_next.prdata[2:0] = s_reg.err;
            astx_pkg::ADDR_BRG:  s_next.prdata[7:0] = s_reg.brg;
            astx_pkg::ADDR_TXS:  s_next.prdata[7:0] = s_reg.txs;
            astx_pkg::ADDR_RXB:  s_next.prdata[7:0] = s_reg.rxb;
            astx_pkg::ADDR_STAT:
            begin
               s_next.prdata[0] = s_reg.tx_st == astx_pkg::TX_RUN;
               s_next.prdata[1] = s_reg.rx_st != astx_pkg::RX_IDLE;
               s_next.prdata[2] = s_reg.rxb_full;
            end
            default: s_next.pslverr = 1'b1;
         endcase
      end
      if (acc & ~pwrite)
      begin
         // only the flags actually reported are cleared, so one
         // raised between setup and access survives
         if (paddr == astx_pkg::ADDR_ERR)
            s_next.err = s_reg.err & ~s_reg.prdata[2:0];
         if (paddr == astx_pkg::ADDR_RXB)
            s_next.rxb_full = 1'b0;
      end
      if (acc & pwrite)
      begin
         case (paddr)
            astx_pkg::ADDR_MODE:
            begin
               s_next.mode     = pwdata[7:0];
               s_next.mode.one = 1'b1;
            end
            astx_pkg::ADDR_BRG:
            begin
               s_next.brg     = pwdata[7:0];
               s_next.brg.rsv = 1'b0;
            end
            default: ;
         endcase
      end

      // --- base clock: prescaler gated by power
      case (s_reg.brg.tps)
         2'd0:    mask = 4'h1;
         2'd1:    mask = 4'h3;
         2'd2:    mask = 4'h7;
         default: mask = 4'hF;
      endcase
      if (s_reg.mode.power)
      begin
         s_next.pre_cnt = s_reg.pre_cnt + 4'h1;
         tick = (s_reg.pre_cnt | ~mask) == astx_pkg::PRE_FULL;
      end
      else
         s_next.pre_cnt = 4'h0;

      // --- receive input: sync, force high while unpowered, filter
      s_next.rx_s1 = serial_rx_pin;
      s_next.rx_s2 = s_reg.rx_s1;
      rx_in = s_reg.mode.power ? s_reg.rx_s2 : 1'b1;
      if (tick)
      begin
         s_next.filt_a = rx_in;
         if (rx_in == s_reg.filt_a)
            s_next.filt = s_reg.filt_a;
         s_next.filt_d = s_reg.filt;
         fall = s_reg.filt_d & ~s_reg.filt;
      end

      // --- transmitter
      if (tick)
      begin
         // period of 2k ticks: k counts twice
         if (s_reg.tx_cnt == km1)
         begin
            s_next.tx_cnt  = 5'h00;
            s_next.tx_half = ~s_reg.tx_half;
            bit_end = s_reg.tx_half;
         end
         else
            s_next.tx_cnt = s_reg.tx_cnt + 5'h01;
      end
      if (s_reg.tx_st == astx_pkg::TX_RUN && bit_end)
      begin
         if (s_reg.tx_left == 4'h1)
         begin
            s_next.tx_st  = astx_pkg::TX_IDLE;
            s_next.tx_pin = 1'b1;
            s_next.tx_irq = 1'b1;
         end
         else
         begin
            s_next.tx_sr   = {1'b1, s_reg.tx_sr[11:1]};
            s_next.tx_pin  = s_reg.tx_sr[1];
            s_next.tx_left = s_reg.tx_left - 4'h1;
         end
      end
      // a write while a frame is in flight is dropped
      if (acc & pwrite & (paddr == astx_pkg::ADDR_TXS)
          & s_reg.mode.power & s_reg.mode.txe
          & (s_reg.tx_st == astx_pkg::TX_IDLE))
      begin
         s_next.txs     = pwdata[7:0];
         s_next.tx_sr   = astx_frame(pwdata[7:0], s_reg.mode);
         s_next.tx_left = astx_body(s_reg.mode)
                          + (s_reg.mode.stop2 ? 4'h3 : 4'h2);
         s_next.tx_pin  = 1'b0;
         s_next.tx_st   = astx_pkg::TX_RUN;
         s_next.tx_cnt  = 5'h00;
         s_next.tx_half = 1'b0;
      end
      if (~s_reg.mode.power | ~s_reg.mode.txe)
      begin
         s_next.tx_st   = astx_pkg::TX_IDLE;
         s_next.tx_cnt  = 5'h00;
         s_next.tx_half = 1'b0;
         s_next.tx_pin  = 1'b1;
      end

      // --- receiver
      case (s_reg.rx_st)
         astx_pkg::RX_IDLE:
         begin
            s_next.rx_cnt  = 5'h00;
            s_next.rx_half = 1'b0;
            if (fall)
               s_next.rx_st = astx_pkg::RX_START;
         end
         astx_pkg::RX_START:
         begin
            if (tick)
            begin
               if (s_reg.rx_cnt == km1)
               begin
                  s_next.rx_cnt = 5'h00;
                  s_next.rx_idx = 4'h0;
                  // low after k ticks: mid start bit
                  s_next.rx_st = s_reg.filt ? astx_pkg::RX_IDLE
                                            : astx_pkg::RX_BITS;
               end
               else
                  s_next.rx_cnt = s_reg.rx_cnt + 5'h01;
            end
         end
         astx_pkg::RX_BITS:
         begin
            if (tick)
            begin
               if (s_reg.rx_cnt == km1)
               begin
                  s_next.rx_cnt  = 5'h00;
                  s_next.rx_half = ~s_reg.rx_half;
                  // own flag: a transmit bit edge must not clock the receiver
                  rx_end = s_reg.rx_half;
               end
               else
                  s_next.rx_cnt = s_reg.rx_cnt + 5'h01;
            end
            if (rx_end)
            begin
               s_next.rx_idx = s_reg.rx_idx + 4'h1;
               if (s_reg.rx_idx < (s_reg.mode.len8 ? 4'h8 : 4'h7))
                  s_next.rx_sr = {s_reg.filt, s_reg.rx_sr[7:1]};
               else if (s_reg.rx_idx < astx_body(s_reg.mode))
                  s_next.rx_par = s_reg.filt;
               else
               begin
                  // only one stop bit is looked at
                  data = s_reg.mode.len8 ? s_reg.rx_sr
                                         : {1'b0, s_reg.rx_sr[7:1]};
                  case (s_reg.mode.par)
                     astx_pkg::PAR_ODD:  perr = ~(^data ^ s_reg.rx_par);
                     astx_pkg::PAR_EVEN: perr = ^data ^ s_reg.rx_par;
                     default:            perr = 1'b0;
                  endcase
                  if (perr)
                     s_next.err.pe = 1'b1;
                  if (~s_reg.filt)
                     s_next.err.fe = 1'b1;
                  if (s_reg.rxb_full)
                     s_next.err.ove = 1'b1;
                  else
                  begin
                     s_next.rxb      = data;
                     s_next.rxb_full = 1'b1;
                  end
                  s_next.rx_irq = 1'b1;
                  s_next.rx_st  = astx_pkg::RX_IDLE;
               end
            end
         end
         default: s_next.rx_st = astx_pkg::RX_IDLE;
      endcase
      if (~s_reg.mode.power | ~s_reg.mode.rxe)
      begin
         s_next.rx_st   = astx_pkg::RX_IDLE;
         s_next.rx_cnt  = 5'h00;
         s_next.rx_half = 1'b0;
         s_next.rx_irq  = 1'b0;
      end

      // power off clears the data holders, held in step with mclk
      if (~s_reg.mode.power)
      begin
         s_next.err      = 3'b000;
         s_next.txs      = 8'h00;
         s_next.rxb      = 8'h00;
         s_next.rxb_full = 1'b0;
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_reg          <= '0;
         s_reg.mode     <= astx_pkg::MODE_RST;
         s_reg.brg      <= astx_pkg::BRG_RST;
         s_reg.rx_s1    <= 1'b1;
         s_reg.rx_s2    <= 1'b1;
         s_reg.filt_a   <= 1'b1;
         s_reg.filt     <= 1'b1;
         s_reg.filt_d   <= 1'b1;
         s_reg.tx_sr    <= 12'hFFF;
         s_reg.tx_pin   <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   assign prdata          = s_reg.prdata;
   assign pready          = s_reg.pready;
   assign pslverr         = s_reg.pslverr;
   assign serial_tx_pin   = s_reg.tx_pin;
   assign tx_complete_irq = s_reg.tx_irq;
   assign rx_complete_irq = s_reg.rx_irq;

endmodule

/* File: rtl/astx_pkg.sv */
// package: register map, field layouts and state types of the serial unit
package astx_pkg;

   // ==========================================
   // register byte offsets
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_ERR  = 8'h04;
   localparam logic [7:0] ADDR_BRG  = 8'h08;
   localparam logic [7:0] ADDR_TXS  = 8'h0C;
   localparam logic [7:0] ADDR_RXB  = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;

   // ==========================================
   // values after reset, and the prescaler's full count
   localparam logic [7:0] MODE_RST = 8'h01;
   localparam logic [7:0] BRG_RST  = 8'h1F;
   localparam logic [3:0] PRE_FULL = 4'hF;

   // ==========================================
   // field layouts
   typedef enum logic [1:0] {
      PAR_NONE,
      PAR_ZERO,
      PAR_ODD,
      PAR_EVEN
   } astx_par_t;

   typedef struct packed {
      logic      power;
      logic      txe;
      logic      rxe;
      astx_par_t par;
      logic      len8;
      logic      stop2;
      logic      one;
   } astx_mode_t;

   typedef struct packed {
      logic [1:0] tps;
      logic       rsv;
      logic [4:0] k;
   } astx_brg_t;

   typedef struct packed {
      logic pe;
      logic fe;
      logic ove;
   } astx_err_t;

   // ==========================================
   // sequencer states
   typedef enum logic {
      TX_IDLE,
      TX_RUN
   } astx_tx_st_t;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_BITS
   } astx_rx_st_t;

   typedef struct packed {
      astx_mode_t  mode;
      astx_brg_t   brg;
      astx_err_t   err;
      logic [7:0]  txs;
      logic [7:0]  rxb;
      logic        rxb_full;
      logic [3:0]  pre_cnt;
      logic        rx_s1;
      logic        rx_s2;
      logic        filt_a;
      logic        filt;
      logic        filt_d;
      astx_tx_st_t tx_st;
      logic [4:0]  tx_cnt;
      logic        tx_half;
      logic [11:0] tx_sr;
      logic [3:0]  tx_left;
      logic        tx_pin;
      logic        tx_irq;
      astx_rx_st_t rx_st;
      logic [4:0]  rx_cnt;
      logic        rx_half;
      logic [3:0]  rx_idx;
      logic [7:0]  rx_sr;
      logic        rx_par;
      logic        rx_irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } astx_state_t;

endpackage

/* File: bench/astx_uart_checker.sv */
// checker: port-level timing properties of the serial unit
`timescale 1ns/10ps

module astx_uart_checker
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset_n,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // serial and events
   input wire logic        serial_tx_pin,
   input wire logic        tx_complete_irq,
   input wire logic        rx_complete_irq
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   // ==========================================
   // register bus
   pready_next_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   pready_one_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_map_a: assert property (pready && paddr > 8'h14
      |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   mode_read_a: assert property (pready && !pwrite && paddr == 8'h00
      |-> !pslverr && prdata[0]) else $error("mode read wrong");

   // ==========================================
   // serial events
   tx_start_a: assert property ($fell(serial_tx_pin)
      |-> !serial_tx_pin [*8])
      else $error("start bit too short");
   tx_done_a: assert property (tx_complete_irq
      |-> serial_tx_pin && $past(serial_tx_pin))
      else $error("tx done while line not at stop");
   tx_pulse_a: assert property (tx_complete_irq |=> !tx_complete_irq)
      else $error("tx done longer than one cycle");
   tx_quiet_a: assert property (tx_complete_irq |=> serial_tx_pin [*2])
      else $error("line left idle without write");
   rx_pulse_a: assert property (rx_complete_irq |=> !rx_complete_irq)
      else $error("rx done longer than one cycle");

   tx_seen_c: cover property (tx_complete_irq);
   rx_seen_c: cover property (rx_complete_irq);
   refuse_c: cover property (pslverr);
endmodule

bind astx_uart astx_uart_checker i_astx_uart_checker (.mclk(mclk),
   .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .serial_tx_pin(serial_tx_pin), .tx_complete_irq(tx_complete_irq),
   .rx_complete_irq(rx_complete_irq));

/* File: bench/astx_partner.sv */
// partner: remote serial device, frame capture and frame sender
`timescale 1ns/10ps

module astx_partner
#(
   parameter int BIT = 32
)
(
   // clock
   input wire logic mclk,
   // serial lines
   input wire logic tx,
   output logic     rx
);
   logic [11:0] got;

   // samples twelve bit slots mid-bit; idle slots read as ones
   initial
   begin
      rx = 1'b1;
      got = 12'h000;
      forever
      begin
         @(negedge tx);
         repeat (BIT / 2) @(posedge mclk);
         for (int i = 0; i < 12; i++)
         begin
            got[i] = tx;
            repeat (BIT) @(posedge mclk);
         end
      end
   end

   task automatic send(input logic [11:0] f);
      @(posedge mclk);
      for (int i = 0; i < 12; i++)
      begin
         rx <= f[i];
         repeat (BIT) @(posedge mclk);
      end
      rx <= 1'b1;
   endtask

   // low pulse longer than the filter, shorter than k ticks
   task automatic glitch;
      @(posedge mclk);
      rx <= 1'b0;
      repeat (10) @(posedge mclk);
      rx <= 1'b1;
   endtask
endmodule

/* File: bench/astx_uart_test.sv */
// testbench: register, transmit and receive scenarios of the serial unit
`timescale 1ns/10ps

module astx_uart_test;
   localparam int BIT = 32; // k=8, tick = 2 mclk

   logic        mclk;
   logic        reset_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rx_pin;
   logic        tx_pin;
   logic        tx_irq;
   logic        rx_irq;
   int          n_errors;
   int          checked;
   int          n_rx;
   int          e_rx;
   logic [31:0] r;
   logic        e;
   logic [7:0]  m;
   logic [7:0]  d;
   logic        bp;

   astx_uart i_astx_uart (.mclk(mclk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin),
      .tx_complete_irq(tx_irq), .rx_complete_irq(rx_irq));
   astx_partner #(.BIT(BIT)) i_astx_partner (.mclk(mclk), .tx(tx_pin),
      .rx(rx_pin));

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   always @(posedge mclk)
      if (rx_irq === 1'b1)
         n_rx++;

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, x);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= v;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask

   // character as stored: 7-bit characters read with bit 7 clear
   function automatic logic [7:0] dat(logic [7:0] v, logic [7:0] md);
      return md[2] ? v : {1'b0, v[6:0]};
   endfunction

   // frame bits in line order, unused slots idle high
   function automatic logic [11:0] frm(logic [7:0] v, logic [7:0] md,
                                       logic bpar, logic bstop);
      logic [11:0] f;
      int          n;
      f = 12'hFFE;
      n = md[2] ? 8 : 7;
      for (int i = 0; i < n; i++)
         f[1+i] = v[i];
      if (md[4:3] != 2'h0)
      begin
         f[n+1] = md[4] ? (^dat(v, md)) ^ !md[3] ^ bpar : 1'b0;
         n++;
      end
      f[n+1] = !bstop;
      return f;
   endfunction

   task automatic finish_test;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      n_errors++;
      finish_test;
   end

   initial
   begin
      n_errors = 0;
      checked = 0;
      n_rx = 0;
      e_rx = 0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      void'($urandom(53069));
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      rd(astx_pkg::ADDR_MODE, 32'h01);
      rd(astx_pkg::ADDR_BRG, 32'h1F);
      apb(1'b0, 8'h18, 32'h0);
      chk({e, r[30:0]}, 32'h80000000);
      wr(astx_pkg::ADDR_BRG, 32'hE8);
      rd(astx_pkg::ADDR_BRG, 32'hC8);
      wr(astx_pkg::ADDR_BRG, 32'h08);
      rd(astx_pkg::ADDR_BRG, 32'h08);
      // every parity type with both character lengths
      for (int i = 0; i < 8; i++)
      begin
         m = {3'b111, i[1:0], i[2], 1'($urandom), 1'b1};
         d = 8'($urandom);
         bp = 1'($urandom);
         wr(astx_pkg::ADDR_MODE, {24'h0, m});
         chk(tx_pin, 1'b1);
         wr(astx_pkg::ADDR_TXS, {24'h0, d});
         // full duplex: a frame comes in while ours goes out
         fork
            i_astx_partner.send(frm(d, m, bp, i == 5));
            for (int j = 0; j < 600 && tx_irq !== 1'b1; j++)
               @(posedge mclk);
         join
         repeat (3 * BIT) @(posedge mclk);
         chk(i_astx_partner.got, frm(d, m, 1'b0, 1'b0));
         e_rx++;
         chk(n_rx, e_rx);
         rd(astx_pkg::ADDR_STAT, 32'h4);
         rd(astx_pkg::ADDR_TXS, {24'h0, d});
         rd(astx_pkg::ADDR_ERR, {bp & m[4], i == 5, 1'b0});
         rd(astx_pkg::ADDR_ERR, 32'h0);
         rd(astx_pkg::ADDR_RXB, dat(d, m));
      end
      // second frame lands on an unread buffer
      i_astx_partner.send(frm(8'h5A, m, 1'b0, 1'b0));
      i_astx_partner.send(frm(8'hA5, m, 1'b0, 1'b0));
      rd(astx_pkg::ADDR_ERR, 32'h1);
      rd(astx_pkg::ADDR_RXB, dat(8'h5A, m));
      i_astx_partner.send(frm(8'h3C, m, 1'b0, 1'b0));
      wr(astx_pkg::ADDR_MODE, 32'h01);
      wr(astx_pkg::ADDR_MODE, {24'h0, m});
      rd(astx_pkg::ADDR_RXB, 32'h0);
      e_rx += 3;
      // receiver off, then a false start edge
      wr(astx_pkg::ADDR_MODE, 32'h81);
      i_astx_partner.send(frm(8'h3C, m, 1'b0, 1'b0));
      wr(astx_pkg::ADDR_MODE, {24'h0, m});
      i_astx_partner.glitch();
      repeat (2 * BIT) @(posedge mclk);
      chk(n_rx, e_rx);
      finish_test;
   end
endmodule
